// ---- shared/sldw_defs.svh ----
// Purpose: register offsets, field positions and reset values of the
//          segment LCD waveform driver
// Assumes: APB byte addressing, one 32-bit word per register
// Notes:   definitions only
`ifndef SLDW_DEFS_SVH
`define SLDW_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SLDW_OFF_CTRL0 8'h00
`define SLDW_OFF_CTRL1 8'h04
`define SLDW_OFF_FPEN 8'h08
`define SLDW_OFF_STATUS 8'h0C
`define SLDW_OFF_SEG0 8'h10
`define SLDW_OFF_SEG3 8'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SLDW_C0_PRESC 2:0
`define SLDW_C0_BIAS 3
`define SLDW_C0_DUTY 5:4
`define SLDW_C0_EN 7
`define SLDW_C1_RUNPS 0
`define SLDW_C1_HALTW 1

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define SLDW_RST_PRESC 3'h0
`define SLDW_RST_BIAS 1'h0
`define SLDW_DUTY_QUARTER 2'h0
`define SLDW_DUTY_FULL 2'h1
`define SLDW_DUTY_HALF 2'h2
`define SLDW_DUTY_THIRD 2'h3
`define SLDW_LVL_V0 2'h0
`define SLDW_LVL_V1 2'h1
`define SLDW_LVL_V2 2'h2
`define SLDW_LVL_V3 2'h3
`define SLDW_PRESCALE_BASE 1024
`define SLDW_BP_NUM 4
`define SLDW_FP_NUM 32

`endif

// ---- shared/sldw_pkg.sv ----
// Purpose: types shared by the segment LCD waveform driver
// Assumes: 8-bit APB address, 32-bit APB data
// Notes:   offsets and codes live in sldw_defs.svh
`default_nettype none
package sldw_pkg;

   typedef enum logic [1:0] {
      BIAS_FULL,
      BIAS_HALF,
      BIAS_THIRD
   } sldw_bias_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } sldw_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } sldw_apb_rsp_t;

   typedef struct packed {
      logic [7:0] bpLevel;
      logic [3:0] bpOe;
      logic [63:0] fpLevel;
      logic [31:0] fpOe;
   } sldw_pins_t;

endpackage

`default_nettype wire

// ---- src/sldw_driver.sv ----
// Purpose: segment LCD waveform driver with APB register slave
// Assumes: inputs synchronous to clk; pin levels coded V0..V3
// Notes:   segment memory is not reset and keeps its contents
//
// Functional notes
// - Reset selects quarter duty with one-third bias, all backplanes used.
// - Reset clears frontplane enables and global enable; all pins undriven.
// - LCD clock divides oscillator clock by 1024 shifted left by prescale code.
// - Frame lasts as many LCD clock periods as active backplanes.
// - Stored one drives segment ON when global and frontplane enables set.
// - Stored zero drives the waveform pair that keeps segment OFF.
// - Segment memory readable and writable by bus at any time.
// - Enable access leaves segment memory alone; memory not reset.
// - Frontplane waveform appears only while global enable also set.
// - Five modes: 1/1 two levels, 1/2 three or four, 1/3, 1/4.
// - Duty code 01 full, 10 half, 11 third, 00 quarter.
// - Bias bit matters only at half duty; others fixed bias.
// - Unused backplane outputs stay undriven.
// - Backplane waveforms repeat every frame, independent of memory.
// - Frontplane waveform built from its segment bits per backplane slot.
// - Wait with halt bit set stops clocks, enabled pins to ground.
// - Pseudo-halt without run bit stops clocks, enabled pins to ground.
// - Memory and control registers kept through wait and pseudo-halt.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`include "sldw_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module sldw_driver
   import sldw_pkg::*;
#(
   parameter int PRESCALE_BASE = `SLDW_PRESCALE_BASE
) (
   input wire logic clk,                 // 20 MHz clock, also oscillator_clock
   input wire logic resetn,              // Synchronous reset, active low
   input wire logic clkEn,               // Freezes all state while low, except while resetn is low
   input wire logic waitMode,            // Chip is in wait mode
   input wire logic pseudoHaltMode,      // Chip is in pseudo-halt mode
   input wire sldw_apb_req_t apbReq,     // APB request from master
   output var sldw_apb_rsp_t apbRsp,     // APB answer, registered
   output var sldw_pins_t pins           // Electrode levels and enables
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] presc;
      logic biasSel;
      logic [1:0] duty;
      logic globalEn;
      logic haltInWait;
      logic runInPseudo;
      logic [31:0] fpEn;
      logic [127:0] seg;
      logic [16:0] div;
      logic phase;
      logic [1:0] slot;
      sldw_apb_rsp_t rsp;
      sldw_pins_t pins;
   } sldw_state_t;

   sldw_state_t st;
   sldw_state_t next_st;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Number of backplanes used for a duty code
   function automatic logic [2:0] bpCount(input logic [1:0] duty);
      case (duty)
         `SLDW_DUTY_FULL: bpCount = 3'h1;
         `SLDW_DUTY_HALF: bpCount = 3'h2;
         `SLDW_DUTY_THIRD: bpCount = 3'h3;
         default: bpCount = 3'h4;
      endcase
   endfunction

   // Bias follows duty; the bias bit only counts at half duty
   function automatic sldw_bias_t biasOf(input logic [1:0] duty,
                                         input logic biasSel);
      case (duty)
         `SLDW_DUTY_FULL: biasOf = BIAS_FULL;
         `SLDW_DUTY_HALF: biasOf = biasSel ? BIAS_THIRD : BIAS_HALF;
         default: biasOf = BIAS_THIRD;
      endcase
   endfunction

   // Backplane level: selected slot swings between the rails,
   // idle slots sit on the middle levels, except at full bias where they also swing
   function automatic logic [1:0] bpWave(input logic active,
                                         input logic phase,
                                         input sldw_bias_t bias);
      if (active || bias == BIAS_FULL) begin
         bpWave = phase ? `SLDW_LVL_V0 : `SLDW_LVL_V3;
      end else if (bias == BIAS_HALF) begin
         bpWave = `SLDW_LVL_V1;
      end else begin
         bpWave = phase ? `SLDW_LVL_V2 : `SLDW_LVL_V1;
      end
   endfunction

   // Frontplane level: ON is the inverse of the selected backplane
   function automatic logic [1:0] fpWave(input logic on,
                                         input logic phase,
                                         input sldw_bias_t bias);
      if (on) begin
         fpWave = phase ? `SLDW_LVL_V3 : `SLDW_LVL_V0;
      end else if (bias == BIAS_FULL) begin
         fpWave = phase ? `SLDW_LVL_V0 : `SLDW_LVL_V3;
      end else if (bias == BIAS_HALF) begin
         fpWave = `SLDW_LVL_V1;
      end else begin
         fpWave = phase ? `SLDW_LVL_V1 : `SLDW_LVL_V2;
      end
   endfunction

   // Half of one LCD clock period in clk cycles
   function automatic logic [16:0] halfPeriod(input logic [2:0] presc);
      logic [17:0] full;
      full = 18'(PRESCALE_BASE) << presc;
      halfPeriod = full[17:1];
   endfunction

   // ----------------------------------------------------------------
   // Derived control
   // ----------------------------------------------------------------
   logic halted;
   logic [2:0] nBp;
   sldw_bias_t bias;

   assign halted = (waitMode && st.haltInWait)
                   || (pseudoHaltMode && !st.runInPseudo);
   assign nBp = bpCount(st.duty);
   assign bias = biasOf(st.duty, st.biasSel);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [16:0] half;
      logic [1:0] segIdx;
      half = halfPeriod(st.presc);
      segIdx = apbReq.paddr[3:2];
      next_st = st;

      // APB slave: answer prepared in setup, pready in access
      next_st.rsp.pready = 1'b0;
      next_st.rsp.pslverr = 1'b0;
      if (apbReq.psel && !apbReq.penable) begin
         next_st.rsp.pready = 1'b1;
         next_st.rsp.prdata = 32'h0000_0000;
         case (apbReq.paddr)
            `SLDW_OFF_CTRL0: begin
               next_st.rsp.prdata[`SLDW_C0_PRESC] = st.presc;
               next_st.rsp.prdata[`SLDW_C0_BIAS] = st.biasSel;
               next_st.rsp.prdata[`SLDW_C0_DUTY] = st.duty;
               next_st.rsp.prdata[`SLDW_C0_EN] = st.globalEn;
            end
            `SLDW_OFF_CTRL1: begin
               next_st.rsp.prdata[`SLDW_C1_RUNPS] = st.runInPseudo;
               next_st.rsp.prdata[`SLDW_C1_HALTW] = st.haltInWait;
            end
            `SLDW_OFF_FPEN: begin
               next_st.rsp.prdata = st.fpEn;
            end
            `SLDW_OFF_STATUS: begin
               next_st.rsp.prdata[1:0] = st.slot;
               next_st.rsp.prdata[2] = st.phase;
               next_st.rsp.prdata[3] = halted;
               next_st.rsp.prdata[4] = st.globalEn && !halted;
            end
            default: begin
               // segment memory read at any time
               if (apbReq.paddr >= `SLDW_OFF_SEG0
                   && apbReq.paddr <= `SLDW_OFF_SEG3
                   && apbReq.paddr[1:0] == 2'h0) begin
                  next_st.rsp.prdata = st.seg[32 * segIdx +: 32];
               end else begin
                  next_st.rsp.pslverr = 1'b1;
               end
            end
         endcase
      end

      // Writes take effect at the edge that completes the access
      if (apbReq.psel && apbReq.penable && st.rsp.pready
          && apbReq.pwrite && !st.rsp.pslverr) begin
         case (apbReq.paddr)
            `SLDW_OFF_CTRL0: begin
               next_st.presc = apbReq.pwdata[`SLDW_C0_PRESC];
               next_st.biasSel = apbReq.pwdata[`SLDW_C0_BIAS];
               next_st.duty = apbReq.pwdata[`SLDW_C0_DUTY];
               next_st.globalEn = apbReq.pwdata[`SLDW_C0_EN];
            end
            `SLDW_OFF_CTRL1: begin
               next_st.runInPseudo = apbReq.pwdata[`SLDW_C1_RUNPS];
               next_st.haltInWait = apbReq.pwdata[`SLDW_C1_HALTW];
            end
            `SLDW_OFF_FPEN: begin
               next_st.fpEn = apbReq.pwdata;
            end
            `SLDW_OFF_STATUS: begin
               next_st.fpEn = st.fpEn;
            end
            default: begin
               // segment memory written at any time
               next_st.seg[32 * segIdx +: 32] = apbReq.pwdata;
            end
         endcase
      end

      // Frame timing
      if (!st.globalEn) begin
         next_st.div = 17'h0_0000;
         next_st.phase = 1'b0;
         next_st.slot = 2'h0;
      end else if (!halted) begin
         // divider of 1024 << prescale, two halves per period
         if (st.div >= half - 17'h0_0001) begin
            next_st.div = 17'h0_0000;
            next_st.phase = !st.phase;
            if (st.phase) begin
               // one slot per LCD clock, wrap after nBp
               if ({1'b0, st.slot} >= nBp - 3'h1) begin
                  next_st.slot = 2'h0;
               end else begin
                  next_st.slot = st.slot + 2'h1;
               end
            end
         end else begin
            next_st.div = st.div + 17'h0_0001;
         end
      end
      // when halted divider, phase and slot simply hold; pin levels go to V0 below

      // Backplane pins
      for (int b = 0; b < `SLDW_BP_NUM; b++) begin
         next_st.pins.bpOe[b] = st.globalEn && (b < int'(nBp));
         if (halted) begin
            next_st.pins.bpLevel[2 * b +: 2] = `SLDW_LVL_V0;
         end else begin
            next_st.pins.bpLevel[2 * b +: 2] =
               bpWave(st.slot == 2'(b), st.phase, bias);
         end
      end

      // Frontplane pins
      for (int f = 0; f < `SLDW_FP_NUM; f++) begin
         next_st.pins.fpOe[f] = st.globalEn && st.fpEn[f];
         if (halted) begin
            next_st.pins.fpLevel[2 * f +: 2] = `SLDW_LVL_V0;
         end else begin
            // ON or OFF per slot from memory
            next_st.pins.fpLevel[2 * f +: 2] =
               fpWave(st.seg[4 * f + int'(st.slot)], st.phase, bias);
         end
      end

      // modes via duty and bias decode above
      if (!resetn) begin
         next_st.duty = `SLDW_DUTY_QUARTER;
         next_st.biasSel = `SLDW_RST_BIAS;
         next_st.presc = `SLDW_RST_PRESC;
         // all enables cleared, all pins undriven
         next_st.globalEn = 1'b0;
         next_st.fpEn = 32'h0000_0000;
         next_st.haltInWait = 1'b0;
         next_st.runInPseudo = 1'b0;
         next_st.div = 17'h0_0000;
         next_st.phase = 1'b0;
         next_st.slot = 2'h0;
         next_st.rsp = '0;
         next_st.pins = '0;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (clkEn || !resetn) begin
         st <= next_st;
      end
   end

   assign apbRsp = st.rsp;
   assign pins = st.pins;

endmodule

`default_nettype wire

// ---- tb/sldw_driver_tb.sv ----
// Purpose: self-checking bench for sldw_driver
// Assumes: PRESCALE_BASE 4, one LCD period is 4 clk at code 0
// Notes: clkEn dropped once to check that backplane levels, backplane enables and frontplane enables 0..19 freeze
`include "sldw_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module sldw_driver_tb import sldw_pkg::*;;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic waitMode = 1'b0;
   logic pseudoHaltMode = 1'b0;
   logic run = 1'b0;
   logic clkEn = 1'b1;
   logic err;
   logic [1:0] prevLvl;
   logic [31:0] rd;
   sldw_apb_req_t apbReq = '0;
   sldw_apb_rsp_t apbRsp;
   sldw_pins_t pins;
   logic [31:0] energy [4];
   int errors = 0;
   int comparisons = 0;
   int cnt = 0;
   int span = 0;
   logic [2:0] mode [5] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h0};
   int nbp [5] = '{1, 2, 2, 3, 4};
   logic [4:0] halt [4] = '{5'h14, 5'h05, 5'h02, 5'h0B};
   always #25 clk = ~clk;
   sldw_driver #(.PRESCALE_BASE(4)) sldw_driver_i (.clk(clk), .resetn(resetn), .clkEn(clkEn),
      .waitMode(waitMode), .pseudoHaltMode(pseudoHaltMode), .apbReq(apbReq),
      .apbRsp(apbRsp), .pins(pins));
   sldw_glass sldw_glass_i (.clk(clk), .run(run), .pins(pins), .energy(energy));
   // Cycles between rises of backplane 0 to the top level
   always @(posedge clk) begin
      prevLvl <= pins.bpLevel[1:0];
      if (pins.bpLevel[1:0] == 2'h3 && prevLvl != 2'h3) begin
         span <= cnt;
         cnt <= 1;
      end else cnt <= cnt + 1;
   end
   // ----
   // Tasks
   // ----
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      apbReq <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (apbRsp.pready !== 1'b1 && n < 20);
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      if (n >= 20) errors++;
   endtask
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask
   task automatic glass(input logic on);
      repeat (4) @(posedge clk);
      run <= 1'b1;
      repeat (32) @(posedge clk);
      run <= 1'b0;
      #1;
      for (int b = 0; b < 4; b++) begin
         chk("energy", on ? (b[0] ? 32 : 96) : 0, energy[b]);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      chk("oe", 32'h0, pins.fpOe | {28'h0, pins.bpOe});
      resetn <= 1'b1;
      rdc("ctrl0", `SLDW_OFF_CTRL0, 32'h0);
      rdc("fpen", `SLDW_OFF_FPEN, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++) xfer(1'b1, 8'h10 + 8'(4 * i), 32'hA5C3_0F00 + i);
      xfer(1'b1, `SLDW_OFF_CTRL0, 32'h80);
      xfer(1'b1, `SLDW_OFF_CTRL0, 32'h00);
      xfer(1'b1, 8'h11, 32'hFFFF_FFFF);
      chk("slverr", 32'h1, {31'h0, err});
      for (int i = 0; i < 4; i++) rdc("seg", 8'h10 + 8'(4 * i), 32'hA5C3_0F00 + i);
      xfer(1'b0, 8'h24, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      chk("unmapped", 32'h0, rd);
      $display("test memory done");
      xfer(1'b1, `SLDW_OFF_FPEN, 32'hFFFF_FFFF);
      for (int i = 0; i < 5; i++) begin
         xfer(1'b1, `SLDW_OFF_CTRL0, {24'h0, 2'h2, mode[i], 3'h0});
         repeat (12 * nbp[i] + 8) @(posedge clk);
         chk("frame", 32'(4 * nbp[i]), span);
         chk("bpOe", 32'(4'hF >> (4 - nbp[i])), {28'h0, pins.bpOe});
      end
      $display("test modes done");
      for (int p = 0; p < 8; p++) begin
         xfer(1'b1, `SLDW_OFF_CTRL0, 32'h80 + p);
         repeat ((48 << p) + 40) @(posedge clk);
         chk("frame", 32'(16 << p), span);
      end
      $display("test prescale done");
      xfer(1'b1, `SLDW_OFF_CTRL0, 32'h80);
      xfer(1'b1, 8'h10, 32'h5);
      glass(1'b1);
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, `SLDW_OFF_CTRL1, {30'h0, halt[i][4:3]});
         waitMode <= halt[i][2];
         pseudoHaltMode <= halt[i][1];
         glass(halt[i][0]);
      end
      @(posedge clk);
      clkEn <= 1'b0;
      @(posedge clk);
      rd = {pins.bpLevel, pins.bpOe, pins.fpOe[19:0]};
      repeat (8) @(posedge clk);
      chk("frozen", rd, {pins.bpLevel, pins.bpOe, pins.fpOe[19:0]});
      clkEn <= 1'b1;
      rdc("ctrl0", `SLDW_OFF_CTRL0, 32'h80);
      rdc("seg", 8'h10, 32'h5);
      xfer(1'b1, `SLDW_OFF_CTRL0, 32'h0);
      repeat (2) @(posedge clk);
      chk("fpOe", 32'h0, pins.fpOe);
      rdc("status", `SLDW_OFF_STATUS, 32'h0);
      $display("test halt done");
      stop_test;
   end
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      stop_test;
   end
endmodule
`default_nettype wire

// ---- tb/sldw_glass.sv ----
// Purpose: passive glass, squared drop across frontplane 0 segments
// Assumes: level codes 0..3 are equal steps
// Notes: sum clears while run is low
`timescale 1ns/100ps
`default_nettype none
module sldw_glass import sldw_pkg::*; (
   input wire logic clk, // Clock
   input wire logic run, // Accumulate while high
   input wire sldw_pins_t pins, // Electrodes
   output var logic [31:0] energy [4] // Sum per backplane
);
   int d;
   always @(posedge clk) begin
      for (int b = 0; b < 4; b++) begin
         d = int'(pins.fpLevel[1:0]) - int'(pins.bpLevel[2 * b +: 2]);
         if (!run) energy[b] <= 32'h0;
         else if (pins.fpOe[0] && pins.bpOe[b]) energy[b] <= energy[b] + 32'(d * d);
      end
   end
endmodule
`default_nettype wire

// ---- tb/sldw_monitor.sv ----
// Purpose: port checker for sldw_driver
// Assumes: control bits shadowed from completed APB writes
// Notes: lag flops line the shadow up with the pin register
`include "sldw_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module sldw_monitor import sldw_pkg::*; (
   input wire logic clk, // Clock
   input wire logic resetn, // Reset, low
   input wire logic clkEn, // Clock enable
   input wire logic waitMode, // Wait mode
   input wire logic pseudoHaltMode, // Pseudo halt
   input wire sldw_apb_req_t apbReq, // APB request
   input wire sldw_apb_rsp_t apbRsp, // APB answer
   input wire sldw_pins_t pins // Electrodes
);
   logic [7:0] c0, c0q;
   logic [1:0] c1;
   logic [31:0] fe, feq;
   logic hq, wr;
   logic [3:0] bm;
   assign wr = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite;
   assign bm = c0q[5:4] == 2'h0 ? 4'hF : 4'hF >> (3'h4 - c0q[5:4]);
   always_ff @(posedge clk) begin
      if (!resetn) begin
         {c0, c0q, c1, fe, feq, hq} <= '0;
      end else if (clkEn) begin
         if (wr && apbReq.paddr == `SLDW_OFF_CTRL0) c0 <= apbReq.pwdata[7:0];
         if (wr && apbReq.paddr == `SLDW_OFF_CTRL1) c1 <= apbReq.pwdata[1:0];
         if (wr && apbReq.paddr == `SLDW_OFF_FPEN) fe <= apbReq.pwdata;
         c0q <= c0;
         feq <= fe;
         hq <= (waitMode && c1[1]) || (pseudoHaltMode && !c1[0]);
      end
   end
   // ----
   // Checks
   // ----
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_setup; apbReq.psel && !apbReq.penable; endsequence
   sequence s_bad; s_setup ##0 apbReq.paddr > 8'h1C; endsequence
   property p_ready; s_setup |=> apbRsp.pready; endproperty
   property p_only; apbRsp.pready |-> $past(apbReq.psel && !apbReq.penable); endproperty
   property p_err; s_bad |=> apbRsp.pslverr && apbRsp.prdata == 32'h0; endproperty
   property p_rst; $rose(resetn) |-> pins.bpOe == 4'h0 && pins.fpOe == 32'h0; endproperty
   property p_bpoe; pins.bpOe == (c0q[7] ? bm : 4'h0); endproperty
   property p_fpoe; pins.fpOe == (c0q[7] ? feq : 32'h0); endproperty
   property p_halt; hq && $past(hq) |-> (!pins.bpOe[0] || pins.bpLevel[1:0] == 2'h0)
      && (!pins.fpOe[0] || pins.fpLevel[1:0] == 2'h0); endproperty
   property p_half; c0q[7] && c0q[5:3] == 3'h4 |-> pins.bpLevel[1:0] != 2'h2
      && pins.fpLevel[1:0] != 2'h2; endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   a_only: assert property (p_only) else $error("ready outside access");
   a_err: assert property (p_err) else $error("unmapped not refused");
   a_rst: assert property (p_rst) else $error("pins driven after reset");
   a_bpoe: assert property (p_bpoe) else $error("backplane enables wrong");
   a_fpoe: assert property (p_fpoe) else $error("frontplane enables wrong");
   a_halt: assert property (p_halt) else $error("halted pin not grounded");
   a_half: assert property (p_half) else $error("half bias level wrong");
endmodule
bind sldw_driver sldw_monitor sldw_monitor_i (.clk, .resetn, .clkEn, .waitMode,
   .pseudoHaltMode, .apbReq, .apbRsp, .pins);
`default_nettype wire
